//--- rtl/udcp_consts.svh
// constants for the dfu command parser
`ifndef UDCP_CONSTS_SVH
`define UDCP_CONSTS_SVH
`define UDCP_HDR_BYTES 4'd8
`define UDCP_OP_PROGRAM 8'h01
`define UDCP_OP_READBACK 8'h02
`define UDCP_OP_BLANK 8'h03
`define UDCP_OP_ERASE 8'h04
`define UDCP_OP_INFO 8'h05
`define UDCP_OP_PREFIX 8'h06
`define UDCP_OP_REBOOT 8'h07
`define UDCP_RQ_TYPE 8'ha1
`define UDCP_RQ_CODE 8'h42
`define UDCP_RQ_VALUE 16'h0023
`define UDCP_RQ_LEN 16'h0004
`define UDCP_VER_MAJOR 8'h01
`define UDCP_VER_MINOR 8'h00
`define UDCP_ST_OK 8'h00
`define UDCP_ST_NOT_BLANK 8'h05
`define UDCP_ST_FAIL 8'h0e
`define UDCP_BLK_SHIFT 10
`define UDCP_INFO_BYTES 5'd20
`endif

//--- rtl/udcp_fifo.sv
// parameterised valid/ready fifo for the upload byte stream
`timescale 1ns/10ps
module udcp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic [WIDTH-1:0] in_data, // write word
   input wire logic in_valid, // write offered
   output logic in_ready, // room available
   output logic [WIDTH-1:0] out_data, // head word
   output logic out_valid, // data available
   input wire logic out_ready // reader takes
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("udcp_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop;
   // pointers with wrap bit give honest full and empty
   always_comb begin
      in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
      out_valid = wr_q != rd_q;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end
   // storage has no reset; only written words are ever read
   always_ff @(posedge clk) begin
      if (push)
         mem_q[wr_q[AW-1:0]] <= in_data;
   end
   assign out_data = mem_q[rd_q[AW-1:0]];
endmodule

//--- rtl/udcp_parser.sv
// dfu download command parser with capability and upload streamer
`timescale 1ns/10ps
`include "udcp_consts.svh"
module udcp_parser
   import udcp_pkg::*;
#(
   parameter logic [15:0] BLOCK_SIZE = 16'h0400, // flash block bytes
   parameter logic [15:0] BLOCK_COUNT = 16'h0100, // flash blocks
   parameter logic [31:0] PART_ID = 32'h1234_5678, // arbitrary value
   parameter logic [31:0] CLASS_REV = 32'h0000_0001, // arbitrary value
   parameter logic [31:0] TOP_ADDR = 32'h0004_0000, // accessible top
   parameter logic [31:0] LOW_ADDR = 32'h0000_2800, // lowest writable
   parameter logic [7:0] SIG0 = 8'h5a, // arbitrary signature byte
   parameter logic [7:0] SIG1 = 8'h3c, // arbitrary signature byte
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic dfu_idle, // dfu core in idle state
   input wire logic dl_start, // pulse: download payload begins
   input wire logic [10:0] dl_len, // payload length, 1024 max
   input wire logic [7:0] dl_byte, // payload byte
   input wire logic dl_valid, // payload byte strobe
   input wire logic setup_valid, // pulse: setup packet present
   input wire logic [7:0] setup_type, // request type
   input wire logic [7:0] setup_code, // request code
   input wire logic [15:0] setup_value, // request value
   input wire logic [15:0] setup_len, // request length
   input wire logic ul_start, // pulse: upload request begins
   input wire logic [7:0] flash_byte, // flash readback byte
   input wire logic flash_valid, // flash readback strobe
   input wire logic status_rd, // pulse: status request served
   input wire logic usb_bus_reset, // pulse: usb bus reset seen
   input wire logic dl_complete, // download finished flag
   output logic cap_ack, // capability request claimed
   output logic prefix_disable_flag, // upload prefix off
   output logic [15:0] prog_block_q, // program start block
   output logic [31:0] prog_len_q, // program length
   output logic [31:0] wr_addr_q, // next image byte address
   output logic wr_strobe_q, // image byte write pulse
   output logic [7:0] wr_data_q, // image byte
   output logic [15:0] rd_block_q, // readback start block
   output logic [31:0] rd_len_q, // readback length
   output logic chk_req_q, // blank check start pulse
   output logic erase_req_q, // erase start pulse
   output logic [15:0] erase_count_q, // erase block count
   input wire logic chk_done, // pulse: blank check finished
   input wire logic chk_blank, // result with chk_done
   output logic [7:0] status_q, // status byte for next report
   output logic error_q, // request dfu error state
   output logic reboot_q, // soft reset pulse
   output logic [7:0] up_data, // upload byte
   output logic up_valid, // upload byte valid
   input wire logic up_ready // upload sink takes byte
);
   initial begin
      if (FIFO_DEPTH != 8)
         $error("udcp_parser expects an eight word fifo");
   end
   // ****************************************
   // helpers
   // ****************************************
   // little endian pick of byte n from a 160-bit image
   function automatic logic [7:0] pick(input logic [159:0] v,
                                       input logic [4:0] n);
      pick = v[{n, 3'b000} +: 8];
   endfunction
   // block number to byte address
   function automatic logic [31:0] blk_addr(input logic [15:0] b);
      blk_addr = {6'h00, b, 10'h000};
   endfunction
   logic [31:0] end_addr;
   logic [63:0] hdr_q, hdr_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] op;
   logic [15:0] hblk;
   logic [31:0] hlen;
   assign op = hdr_q[7:0];
   assign hblk = hdr_q[31:16];
   assign hlen = hdr_q[63:32];
   // ****************************************
   // download header capture
   // ****************************************
   typedef enum logic [3:0] {
      S_SKIP = 4'b0001, S_HDR = 4'b0010, S_EXEC = 4'b0100, S_DATA = 4'b1000
   } udcp_dl_type;
   udcp_dl_type st_q, st_d;
   logic prefix_q, prefix_d;
   logic [15:0] pb_d, rb_d, ec_d;
   logic [31:0] pl_d, rl_d, wa_d;
   logic chk_d, er_d, rb_go, err_d, ws_d;
   logic info_q, info_d;
   logic [7:0] stat_d, wdat_d;
   always_comb begin
      st_d = st_q;
      hdr_d = hdr_q;
      cnt_d = cnt_q;
      prefix_d = prefix_q;
      pb_d = prog_block_q;
      pl_d = prog_len_q;
      rb_d = rd_block_q;
      rl_d = rd_len_q;
      ec_d = erase_count_q;
      wa_d = wr_addr_q;
      chk_d = 1'b0;
      er_d = 1'b0;
      rb_go = 1'b0;
      ws_d = 1'b0;
      wdat_d = wr_data_q;
      info_d = info_q;
      err_d = error_q;
      stat_d = status_q;
      end_addr = blk_addr(hblk) + hlen;
      if (op == `UDCP_OP_ERASE)
         end_addr = blk_addr(hblk) + blk_addr(hlen[15:0]);
      unique case (st_q)
         S_SKIP, S_DATA: begin
            // non-idle payloads are raw image data only in S_DATA; S_SKIP drops them
            if (st_q == S_DATA && dl_valid) begin
               ws_d = 1'b1;
               wdat_d = dl_byte;
               wa_d = wr_addr_q + 32'h1;
            end
         end
         S_HDR: begin
            if (dl_valid) begin
               hdr_d = {dl_byte, hdr_q[63:8]};
               cnt_d = cnt_q + 4'd1;
               if (cnt_q == `UDCP_HDR_BYTES - 4'd1)
                  st_d = S_EXEC;
            end
         end
         S_EXEC: begin
            st_d = S_SKIP;
            unique case (op)
               `UDCP_OP_PROGRAM, `UDCP_OP_READBACK,
               `UDCP_OP_BLANK, `UDCP_OP_ERASE: begin
                  if (blk_addr(hblk) < LOW_ADDR || end_addr > TOP_ADDR) begin
                     err_d = 1'b1;
                     stat_d = `UDCP_ST_FAIL;
                  end else if (op == `UDCP_OP_PROGRAM) begin
                     pb_d = hblk;
                     pl_d = hlen;
                     // the stream has no stall, so byte eight is kept
                     wa_d = blk_addr(hblk) + {31'h0, dl_valid};
                     ws_d = dl_valid;
                     wdat_d = dl_byte;
                     st_d = S_DATA;
                  end else if (op == `UDCP_OP_READBACK) begin
                     rb_d = hblk;
                     rl_d = hlen;
                     info_d = 1'b0;
                  end else if (op == `UDCP_OP_BLANK) begin
                     chk_d = 1'b1;
                  end else begin
                     ec_d = hlen[15:0];
                     er_d = 1'b1;
                  end
               end
               `UDCP_OP_INFO: info_d = 1'b1;
               `UDCP_OP_PREFIX: prefix_d = hdr_q[8];
               `UDCP_OP_REBOOT: rb_go = 1'b1;
               default: begin
                  err_d = 1'b1;
                  stat_d = `UDCP_ST_FAIL;
               end
            endcase
         end
      endcase
      // new payload: header only when the core is idle
      if (dl_start) begin
         cnt_d = '0;
         if (dl_len == 11'd0)
            st_d = S_SKIP;
         else if (dfu_idle)
            st_d = S_HDR;
         else if (st_q != S_DATA)
            st_d = S_SKIP;
      end
      if (chk_done)
         stat_d = chk_blank ? `UDCP_ST_OK : `UDCP_ST_NOT_BLANK;
      if (status_rd && !error_q && !chk_done)
         stat_d = `UDCP_ST_OK;
      if (error_q && dfu_idle && st_q != S_EXEC)
         err_d = 1'b0;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= S_SKIP;
         hdr_q <= '0;
         cnt_q <= '0;
         prefix_q <= 1'b0;
         prog_block_q <= '0;
         prog_len_q <= '0;
         rd_block_q <= '0;
         rd_len_q <= '0;
         erase_count_q <= '0;
         wr_addr_q <= '0;
         wr_strobe_q <= 1'b0;
         wr_data_q <= '0;
         chk_req_q <= 1'b0;
         erase_req_q <= 1'b0;
         info_q <= 1'b0;
         error_q <= 1'b0;
         status_q <= `UDCP_ST_OK;
         reboot_q <= 1'b0;
      end else begin
         st_q <= st_d;
         hdr_q <= hdr_d;
         cnt_q <= cnt_d;
         prefix_q <= prefix_d;
         prog_block_q <= pb_d;
         prog_len_q <= pl_d;
         rd_block_q <= rb_d;
         rd_len_q <= rl_d;
         erase_count_q <= ec_d;
         wr_addr_q <= wa_d;
         wr_strobe_q <= ws_d;
         wr_data_q <= wdat_d;
         chk_req_q <= chk_d;
         erase_req_q <= er_d;
         info_q <= info_d;
         error_q <= err_d;
         status_q <= stat_d;
         reboot_q <= rb_go || (usb_bus_reset && dl_complete);
      end
   end
   assign prefix_disable_flag = prefix_q;
   // ****************************************
   // capability request and upload stream
   // ****************************************
   // capability claim is a decode of the present setup packet
   assign cap_ack = setup_valid && setup_type == `UDCP_RQ_TYPE &&
      setup_code == `UDCP_RQ_CODE && setup_value == `UDCP_RQ_VALUE &&
      setup_len == `UDCP_RQ_LEN;
   typedef enum logic [3:0] {
      U_IDLE = 4'b0001, U_GEN = 4'b0010, U_FLASH = 4'b0100,
      U_CAP = 4'b1000
   } udcp_up_type;
   udcp_up_type us_q, us_d;
   logic [4:0] ui_q, ui_d, ulim;
   logic [159:0] img;
   logic [7:0] f_in;
   logic f_valid, f_ready;
   always_comb begin
      img = '0;
      ulim = `UDCP_INFO_BYTES;
      if (us_q == U_CAP) begin
         img[31:0] = {`UDCP_VER_MINOR, `UDCP_VER_MAJOR, SIG1, SIG0};
         ulim = 5'd4;
      end else if (info_q) begin
         img = {LOW_ADDR, TOP_ADDR, CLASS_REV, PART_ID,
                BLOCK_COUNT, BLOCK_SIZE};
      end else begin
         img[63:0] = {rd_len_q, rd_block_q, 8'h00, `UDCP_OP_PROGRAM};
         ulim = 5'd8;
      end
      us_d = us_q;
      ui_d = ui_q;
      f_in = pick(img, ui_q);
      f_valid = 1'b0;
      unique case (us_q)
         U_IDLE: begin
            ui_d = '0;
            if (cap_ack)
               us_d = U_CAP;
            else if (ul_start && (info_q || prefix_q))
               us_d = info_q ? U_GEN : U_FLASH;
            else if (ul_start)
               us_d = U_GEN;
         end
         U_GEN, U_CAP: begin
            f_valid = 1'b1;
            if (f_ready) begin
               ui_d = ui_q + 5'd1;
               if (ui_q == ulim - 5'd1)
                  us_d = (us_q == U_GEN && !info_q) ? U_FLASH : U_IDLE;
            end
         end
         U_FLASH: begin
            // flash bytes stream until the next upload or command
            f_in = flash_byte;
            f_valid = flash_valid;
            if (ul_start || dl_start)
               us_d = U_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         us_q <= U_IDLE;
         ui_q <= '0;
      end else begin
         us_q <= us_d;
         ui_q <= ui_d;
      end
   end
   // flash bytes have no stall path; the core must throttle flash_valid
   udcp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_data(f_in),
      .in_valid(f_valid),
      .in_ready(f_ready),
      .out_data(up_data),
      .out_valid(up_valid),
      .out_ready(up_ready)
   );
   // ****************************************
   // checks
   // ****************************************
   a_prefix_reset: assert property (@(posedge clk)
      $fell(rst) |-> !prefix_disable_flag)
      else $error("prefix not enabled after reset");
   a_bad_opcode: assert property (@(posedge clk) disable iff (rst)
      st_q == S_EXEC && (op == 8'h00 || op > 8'h07) |=> error_q)
      else $error("unknown opcode did not raise error");
   a_idle_only: assert property (@(posedge clk) disable iff (rst)
      dl_start && !dfu_idle |=> st_q != S_HDR)
      else $error("header parsed outside idle");
   a_header_len: assert property (@(posedge clk) disable iff (rst)
      st_q == S_EXEC |-> cnt_q == 4'd8)
      else $error("header length wrong");
   a_cap_decode: assert property (@(posedge clk) disable iff (rst)
      cap_ack |-> setup_code == 8'h42 && setup_type == 8'ha1)
      else $error("capability decode wrong");
   a_prog_addr: assert property (@(posedge clk) disable iff (rst)
      st_q == S_EXEC && st_d == S_DATA |=> prog_block_q == $past(hblk) &&
      wr_addr_q == {6'h00, prog_block_q, 10'h000} + {31'h0, $past(dl_valid)})
      else $error("program address wrong");
   a_prefix_sel: assert property (@(posedge clk) disable iff (rst)
      st_q == S_EXEC && op == 8'h06 |=> prefix_disable_flag == $past(hdr_q[8]))
      else $error("prefix select not applied");
   a_check_stat: assert property (@(posedge clk) disable iff (rst)
      chk_done |=> status_q == ($past(chk_blank) ? 8'h00 : 8'h05))
      else $error("blank check status wrong");
   a_reboot: assert property (@(posedge clk) disable iff (rst)
      st_q == S_EXEC && op == 8'h07 |=> reboot_q ##1 !reboot_q)
      else $error("reboot pulse wrong");
endmodule

//--- rtl/udcp_pkg.sv
// types shared by the parser files
package udcp_pkg;
   typedef logic [7:0] udcp_byte_type;
endpackage

//--- dv/udcp_far_model.sv
// far side model: flash readback source and blank check engine
`timescale 1ns/10ps
module udcp_far_model (
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic ul_start, // upload begins
   input wire logic feed, // readback wanted
   input wire logic chk_req, // blank check start
   input wire logic blank_mode, // result to give
   output logic [7:0] flash_byte, // readback byte
   output logic flash_valid, // readback strobe
   output logic chk_done, // check finished
   output logic chk_blank // result with done
);
   logic [7:0] ucnt;
   logic [7:0] fb;
   logic [2:0] ccnt;
   // late, sparse readback so the fifo fills behind the prefix first
   always_ff @(posedge clk) begin
      if (rst || ul_start)
         ucnt <= 8'h00;
      else if (ucnt != 8'hff)
         ucnt <= ucnt + 8'h01;
   end
   // sixteen bytes per upload; between strobes the line shows junk
   assign fb = 8'h80 + ((ucnt - 8'd40) >> 2);
   assign flash_valid = feed && ucnt >= 8'd40 && ucnt < 8'd104 &&
                        ucnt[1:0] == 2'b00;
   assign flash_byte = flash_valid ? fb : ~fb;
   // check engine answers six cycles after the request
   always_ff @(posedge clk) begin
      if (rst)
         ccnt <= 3'd0;
      else if (chk_req)
         ccnt <= 3'd6;
      else if (ccnt != 3'd0)
         ccnt <= ccnt - 3'd1;
   end
   assign chk_done = (ccnt == 3'd1);
   assign chk_blank = chk_done ? blank_mode : ~blank_mode;
endmodule

//--- dv/tb.sv
// self-checking bench for the dfu command parser
`timescale 1ns/10ps
module tb
   import udcp_pkg::*;
;
   // ****************************************
   // signals and expectations
   // ****************************************
   localparam logic [15:0] BS = 16'h0400;
   localparam logic [15:0] BC = 16'h0100;
   localparam logic [31:0] PID = 32'h1234_5678;
   localparam logic [31:0] CR = 32'h0000_0001;
   localparam logic [31:0] TOP = 32'h0004_0000;
   localparam logic [31:0] LOW = 32'h0000_2800;
   localparam logic [15:0] SIG = 16'h3c5a; // arbitrary value
   localparam logic [159:0] INFO = {LOW, TOP, CR, PID, BC, BS};
   localparam logic [63:0] PFX = {32'h10, 16'h000b, 8'h00, 8'h01};
   logic clk = 0, rst = 1, dfu_idle = 1, dl_start = 0, dl_valid = 0;
   logic [10:0] dl_len = 0;
   logic [7:0] dl_byte = 0, setup_type = 0, setup_code = 0;
   logic [15:0] setup_value = 0, setup_len = 0;
   logic setup_valid = 0, ul_start = 0, status_rd = 0, usb_bus_reset = 0;
   logic dl_complete = 0, up_ready = 0, feed = 0, blank_mode = 0;
   logic flash_valid, chk_done, chk_blank, cap_ack, pfx_off, wr_strobe_q;
   logic [7:0] flash_byte, wr_data_q, status_q, up_data;
   logic [15:0] prog_block_q, rd_block_q, erase_count_q;
   logic [31:0] prog_len_q, wr_addr_q, rd_len_q;
   logic chk_req_q, erase_req_q, error_q, reboot_q, up_valid;
   udcp_byte_type upq[$], wrq[$];
   logic [31:0] wra[$];
   int err_count = 0, comparisons = 0, n_reb = 0, n_era = 0, n_chk = 0;
   int err_hits = 0;
   logic [7:0] err_st;
   logic [7:0] eop[3] = '{8'h09, 8'h01, 8'h04};
   logic [15:0] eblk[3] = '{16'h0000, 16'h0005, 16'h00ff};
   logic [31:0] elen[3] = '{32'h0, 32'h100, 32'h2};
   udcp_parser #(.BLOCK_SIZE(BS), .BLOCK_COUNT(BC), .PART_ID(PID),
      .CLASS_REV(CR), .TOP_ADDR(TOP), .LOW_ADDR(LOW), .SIG0(SIG[7:0]),
      .SIG1(SIG[15:8])) uut (.clk(clk),
      .rst(rst), .dfu_idle(dfu_idle), .dl_start(dl_start), .dl_len(dl_len),
      .dl_byte(dl_byte), .dl_valid(dl_valid), .setup_valid(setup_valid),
      .setup_type(setup_type), .setup_code(setup_code),
      .setup_value(setup_value), .setup_len(setup_len),
      .ul_start(ul_start), .flash_byte(flash_byte),
      .flash_valid(flash_valid), .status_rd(status_rd),
      .usb_bus_reset(usb_bus_reset), .dl_complete(dl_complete),
      .cap_ack(cap_ack), .prefix_disable_flag(pfx_off),
      .prog_block_q(prog_block_q), .prog_len_q(prog_len_q),
      .wr_addr_q(wr_addr_q), .wr_strobe_q(wr_strobe_q),
      .wr_data_q(wr_data_q), .rd_block_q(rd_block_q), .rd_len_q(rd_len_q),
      .chk_req_q(chk_req_q), .erase_req_q(erase_req_q),
      .erase_count_q(erase_count_q), .chk_done(chk_done),
      .chk_blank(chk_blank), .status_q(status_q), .error_q(error_q),
      .reboot_q(reboot_q), .up_data(up_data), .up_valid(up_valid),
      .up_ready(up_ready));
   udcp_far_model far (.clk(clk), .rst(rst), .ul_start(ul_start),
      .feed(feed), .chk_req(chk_req_q), .blank_mode(blank_mode),
      .flash_byte(flash_byte), .flash_valid(flash_valid),
      .chk_done(chk_done), .chk_blank(chk_blank));
   // 40 mhz clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   // monitor: gathers streams and counts one-cycle pulses
   always @(posedge clk) begin
      if (up_valid === 1'b1 && up_ready) upq.push_back(up_data);
      if (wr_strobe_q === 1'b1) begin
         wrq.push_back(wr_data_q);
         wra.push_back(wr_addr_q - 32'h1);
      end
      if (reboot_q === 1'b1) n_reb++;
      if (erase_req_q === 1'b1) n_era++;
      if (chk_req_q === 1'b1) n_chk++;
      if (error_q === 1'b1) begin
         err_hits++;
         err_st = status_q;
      end
   end
   // ****************************************
   // access tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, exp, input string m);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // header plus nx image bytes; waits past the execute cycle
   task automatic cmd(input logic [7:0] op, f1, input logic [15:0] blk,
                      input logic [31:0] ln, input int nx);
      logic [7:0] h[8];
      h = '{op, f1, blk[7:0], blk[15:8], ln[7:0], ln[15:8], ln[23:16],
            ln[31:24]};
      dl_start <= 1'b1;
      dl_len <= 11'(8 + nx);
      @(posedge clk);
      dl_start <= 1'b0;
      for (int i = 0; i < 8 + nx; i++) begin
         dl_byte <= (i < 8) ? h[i] : 8'(8'hc0 + i);
         dl_valid <= 1'b1;
         @(posedge clk);
      end
      dl_valid <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   // sink stalls 20 cycles so the info upload fills the fifo and is refused first
   task automatic upload(input int n, input logic st, fd);
      int w = 0;
      upq.delete();
      feed <= fd;
      ul_start <= st;
      up_ready <= 1'b0;
      @(posedge clk);
      ul_start <= 1'b0;
      repeat (20) @(posedge clk);
      up_ready <= 1'b1;
      while (upq.size() < n && w < 300) begin
         @(posedge clk);
         w++;
      end
      chk(upq.size(), n, "upload byte count");
      feed <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog, far beyond the expected few hundred cycles
   initial begin
      #300us;
      err_count++;
      give_verdict();
   end
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(pfx_off, 0, "prefix after reset");
      chk(status_q, 8'h00, "status after reset");
      setup_type <= 8'ha1;
      setup_code <= 8'h42;
      setup_value <= 16'h0023;
      setup_len <= 16'h0004;
      setup_valid <= 1'b1;
      @(posedge clk);
      chk(cap_ack, 1, "capability claimed");
      setup_valid <= 1'b0;
      upload(4, 1'b0, 1'b0);
      chk({upq[1], upq[0]}, SIG, "capability signature");
      chk({upq[2], upq[3]}, 16'h0100, "capability version");
      setup_code <= 8'h43;
      setup_valid <= 1'b1;
      @(posedge clk);
      chk(cap_ack, 0, "wrong code claimed");
      setup_valid <= 1'b0;
      $display("capability test done");
      cmd(8'h01, 8'h00, 16'h000a, 32'h0000_0100, 2);
      chk(prog_block_q, 16'h000a, "program block");
      chk(prog_len_q, 32'h100, "program length");
      for (int i = 0; i < 2; i++) begin
         chk(wra[i], 32'h2800 + i, "image address");
         chk(wrq[i], 8'hc8 + i, "image byte");
      end
      $display("program test done");
      cmd(8'h02, 8'h00, 16'h000b, 32'h0000_0010, 0);
      chk({rd_block_q, rd_len_q[15:0]}, 32'h000b_0010, "read region");
      upload(24, 1'b1, 1'b1);
      for (int i = 0; i < 24; i++)
         chk(upq[i], i < 8 ? PFX[8*i +: 8] : 8'h78 + i, "upload");
      cmd(8'h06, 8'h01, 16'h0000, 32'h0, 0);
      chk(pfx_off, 1, "prefix off");
      upload(16, 1'b1, 1'b1);
      chk(upq[0], 8'h80, "upload without prefix");
      cmd(8'h06, 8'h00, 16'h0000, 32'h0, 0);
      chk(pfx_off, 0, "prefix back on");
      cmd(8'h05, 8'h00, 16'h0000, 32'h0, 0);
      upload(20, 1'b1, 1'b0);
      for (int i = 0; i < 20; i++)
         chk(upq[i], INFO[8*i +: 8], "info byte");
      $display("upload tests done");
      for (int b = 1; b >= 0; b--) begin
         blank_mode <= b[0];
         cmd(8'h03, 8'h00, 16'h000a, 32'h0000_0400, 0);
         repeat (6) @(posedge clk);
         chk(status_q, b ? 8'h00 : 8'h05, "blank status");
         status_rd <= 1'b1;
         @(posedge clk);
         status_rd <= 1'b0;
         repeat (2) @(posedge clk);
         chk(status_q, 8'h00, "status after report");
      end
      chk(n_chk, 2, "check requests");
      cmd(8'h04, 8'h00, 16'h0010, 32'h0000_0003, 0);
      chk(erase_count_q, 16'h0003, "erase count");
      chk(n_era, 1, "erase request");
      cmd(8'h07, 8'h00, 16'h0000, 32'h0, 0);
      chk(n_reb, 1, "soft reboot");
      dl_complete <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         usb_bus_reset <= 1'b1;
         @(posedge clk);
         usb_bus_reset <= 1'b0;
         dl_complete <= 1'b0;
         repeat (3) @(posedge clk);
      end
      chk(n_reb, 2, "bus reset reboot");
      $display("flash command tests done");
      // open a program region, then end the download with no data
      cmd(8'h01, 8'h00, 16'h000a, 32'h0000_0100, 0);
      dl_start <= 1'b1;
      dl_len <= 11'd0;
      @(posedge clk);
      dl_start <= 1'b0;
      dfu_idle <= 1'b0;
      repeat (2) @(posedge clk);
      cmd(8'h02, 8'h00, 16'h0030, 32'h0000_0020, 0);
      chk(rd_block_q, 16'h000b, "non-idle payload parsed");
      chk(wrq.size(), 2, "data after end of download");
      dfu_idle <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         err_hits = 0;
         cmd(eop[k], 8'h00, eblk[k], elen[k], 0);
         chk(err_hits > 0, 1, "error state");
         chk(err_st, 8'h0e, "fail status");
      end
      $display("error tests done");
      give_verdict();
   end
endmodule
